// [rtl/clkctl_port.sv]
// serial control port, reset and power-down logic of a clock generator
`include "clkctl_params.svh"
`default_nettype none

// Summary of operation
// - supply-up loads defaults, then syncs outputs
// - reset pin low returns registers to defaults
// - soft reset set and cleared via two bits
// - soft reset acts without update command
// - sleep pin low powers down core blocks
// - serial port keeps working during sleep
// - wake-up uses held or newly written settings
// - no calibration on wake; release of sleep syncs outputs
// - async PLL power-down right at update
// - sync PLL power-down at charge-pump event
// - distribution power-down bit; also sync trigger
// - LVPECL two-bit power-down mode decode
// - each output individually powered down
// - sample on rising, drive on falling edge
// - direction bit moves readback to separate pin
// - chip select high tristates; falling starts cycle
// - stall on byte boundaries keeps position, except in streaming
// - off-boundary chip select rise drops partial data, ends transfer
// - streaming auto-steps address until chip select or until the top register is done
// - sixteen-bit instruction precedes data
// - instruction decodes direction, length, address
// - instruction layout: rw, length, address
// - address decrements msb-first, increments lsb-first
// - shadow writes; update copies to active
// - streaming stops at top register
module clkctl_port
	import clkctl_pkg::*;
#(
	parameter int N_PECL = `N_PECL_OUT,
	parameter int N_LVDS = `N_LVDS_OUT
) (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                reset,
	// device pins
	input  wire logic                reset_pin_n,
	input  wire logic                sleep_pin_n,
	input  wire logic                sclk,
	input  wire logic                cs_n,
	input  wire logic                sdio_in,
	output logic                     sdio_out,
	output logic                     sdio_oe,
	output logic                     separate_readback_pin,
	output logic                     separate_readback_oe,
	// core side
	input  wire logic                cp_event,
	input  wire logic                reg_hold,
	output logic                     write_ready,
	output logic                     pll_pd,
	output logic                     core_off,
	output logic                     dist_pd,
	output logic                     sync_hold,
	output logic [2*N_PECL-1:0]      pecl_mode,
	output logic [N_LVDS-1:0]        lvds_off
);
	import clkctl_pkg::*;

	localparam int NREG     = N_PECL + N_LVDS + 2;
	localparam int SLOT_W   = $clog2(NREG);
	localparam int SL_LVDS  = N_PECL + 1;
	localparam int SL_DIST  = N_PECL + N_LVDS + 1;

	// ==================================================================
	// pin synchronisers
	logic [4:0] pin_s1_q, pin_s2_q;
	logic       sclk_s3_q, cs_s3_q;
	logic       sclk_s, cs_s, din_s, sleep_s, rstpin_s;
	logic       rise, fall, cs_rise, rst_all;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			// idle levels: sclk low, cs high, so no false edge after reset
			pin_s1_q  <= 5'h1A;
			pin_s2_q  <= 5'h1A;
			sclk_s3_q <= 1'b0;
			cs_s3_q   <= 1'b1;
		end else begin
			pin_s1_q  <= {reset_pin_n, sleep_pin_n, sdio_in, cs_n, sclk};
			pin_s2_q  <= pin_s1_q;
			sclk_s3_q <= pin_s2_q[0];
			cs_s3_q   <= pin_s2_q[1];
		end
	end

	assign sclk_s     = pin_s2_q[0];
	assign cs_s       = pin_s2_q[1];
	assign din_s      = pin_s2_q[2];
	assign sleep_s    = ~pin_s2_q[3];
	assign rstpin_s   = ~pin_s2_q[4];
	assign rise       = sclk_s & ~sclk_s3_q & ~cs_s;
	assign fall       = ~sclk_s & sclk_s3_q & ~cs_s;
	assign cs_rise    = cs_s & ~cs_s3_q;
	assign rst_all    = reset | rstpin_s;

	// ==================================================================
	// address helpers
	function automatic logic [SLOT_W:0] slot_of(input addr_t a);
		slot_of = '0;
		if (a == `ADDR_PLL_MODE) begin
			slot_of = {1'b1, SLOT_W'(0)};
		end else if (a >= `ADDR_PECL_BASE && a < `ADDR_PECL_BASE + 13'(N_PECL)) begin
			slot_of = {1'b1, SLOT_W'(a - `ADDR_PECL_BASE + 13'h001)};
		end else if (a >= `ADDR_LVDS_BASE && a < `ADDR_LVDS_BASE + 13'(N_LVDS)) begin
			slot_of = {1'b1, SLOT_W'(a - `ADDR_LVDS_BASE + 13'(SL_LVDS))};
		end else if (a == `ADDR_DIST) begin
			slot_of = {1'b1, SLOT_W'(SL_DIST)};
		end
	endfunction

	function automatic addr_t step_addr(input addr_t a, input logic lsb);
		if (lsb) begin
			step_addr = 13'(a + 13'h001);
		end else begin
			step_addr = (a == 13'h000) ? `ADDR_LAST : 13'(a - 13'h001);
		end
	endfunction

	// ==================================================================
	// configuration state
	byte_t        shadow_q [NREG];
	byte_t        shadow_d [NREG];
	byte_t        active_q [NREG];
	byte_t        active_d [NREG];
	byte_t        port_cfg_q, port_cfg_d;
	byte_t        rb_sel_q, rb_sel_d;
	logic         pll_pd_q, pll_pd_d;
	logic         pd_pend_q, pd_pend_d;
	logic         lsb_first, unidir, soft_rst;
	logic         buf_valid, buf_ready;
	logic [20:0]  buf_data;
	addr_t        wr_addr;
	byte_t        wr_byte;
	logic [SLOT_W:0] wslot;

	assign lsb_first = port_cfg_q[`BIT_LSB_FIRST];
	assign unidir    = port_cfg_q[`BIT_UNIDIR];
	assign soft_rst  = port_cfg_q[`BIT_SRST] & port_cfg_q[`BIT_SRST_MIRROR];
	assign wr_addr   = buf_data[20:8];
	assign wr_byte   = buf_data[7:0];
	assign wslot     = slot_of(wr_addr);

	always_comb begin
		shadow_d   = shadow_q;
		active_d   = active_q;
		port_cfg_d = port_cfg_q;
		rb_sel_d   = rb_sel_q;
		pll_pd_d   = pll_pd_q;
		pd_pend_d  = pd_pend_q;
		if (buf_valid && !reg_hold) begin
			if (wr_addr == `ADDR_PORT_CFG) begin
				port_cfg_d = wr_byte;
			end else if (wr_addr == `ADDR_RB_SEL) begin
				rb_sel_d = wr_byte;
			end else if (wr_addr == `ADDR_UPDATE && wr_byte[`BIT_UPDATE]) begin
				active_d = shadow_q;
				if (shadow_q[0][1:0] == `PLL_ASYNC_PD) begin
					pll_pd_d  = 1'b1;
					pd_pend_d = 1'b0;
				end else if (shadow_q[0][1:0] == `PLL_SYNC_PD) begin
					pd_pend_d = ~pll_pd_q;
				end else begin
					pll_pd_d  = 1'b0;
					pd_pend_d = 1'b0;
				end
			end else if (wslot[SLOT_W]) begin
				shadow_d[wslot[SLOT_W-1:0]] = wr_byte;
			end
		end
		if (pd_pend_q && cp_event) begin
			pll_pd_d  = 1'b1;
			pd_pend_d = 1'b0;
		end
		if (soft_rst) begin
			// no update needed: defaults land in both copies at once
			for (int i = 0; i < NREG; i++) begin
				shadow_d[i] = `RST_CFG_REG;
				active_d[i] = `RST_CFG_REG;
			end
			rb_sel_d  = `RST_RB_SEL;
			pll_pd_d  = 1'b0;
			pd_pend_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst_all) begin
			for (int i = 0; i < NREG; i++) begin
				shadow_q[i] <= `RST_CFG_REG;
				active_q[i] <= `RST_CFG_REG;
			end
			port_cfg_q <= `RST_PORT_CFG;
			rb_sel_q   <= `RST_RB_SEL;
			pll_pd_q   <= 1'b0;
			pd_pend_q  <= 1'b0;
		end else begin
			shadow_q   <= shadow_d;
			active_q   <= active_d;
			port_cfg_q <= port_cfg_d;
			rb_sel_q   <= rb_sel_d;
			pll_pd_q   <= pll_pd_d;
			pd_pend_q  <= pd_pend_d;
		end
	end

	// ==================================================================
	// serial engine
	port_state_t state_q, state_d;
	logic [2:0]  pos_q, pos_d;
	logic        ibyte_q, ibyte_d;
	logic [15:0] isr_q, isr_d;
	byte_t       dsr_q, dsr_d;
	byte_t       new_byte;
	logic        rw_q, rw_d;
	logic [1:0]  len_q, len_d;
	logic [1:0]  cnt_q, cnt_d;
	addr_t       addr_q, addr_d;
	logic        load_q, load_d;
	logic        push;
	logic [15:0] instr;

	assign new_byte = lsb_first ? {din_s, dsr_q[7:1]} : {dsr_q[6:0], din_s};
	assign instr    = lsb_first ? {din_s, isr_q[15:1]} : {isr_q[14:0], din_s};

	always_comb begin
		state_d = state_q;
		pos_d   = pos_q;
		ibyte_d = ibyte_q;
		isr_d   = isr_q;
		dsr_d   = dsr_q;
		rw_d    = rw_q;
		len_d   = len_q;
		cnt_d   = cnt_q;
		addr_d  = addr_q;
		load_d  = 1'b0;
		push    = 1'b0;
		if (cs_rise && (pos_q != 3'h0 || state_q == ST_DONE
				|| (state_q == ST_DATA && len_q == 2'h3))) begin
			// off-boundary rise or end of cycle: drop partial data
			state_d = ST_INSTR;
			pos_d   = 3'h0;
			ibyte_d = 1'b0;
		end else if (rise) begin
			pos_d = 3'(pos_q + 3'h1);
			case (state_q)
				ST_INSTR: begin
					isr_d = instr;
					if (pos_q == 3'h7) begin
						ibyte_d = 1'b1;
						if (ibyte_q) begin
							rw_d    = instr[15];
							len_d   = instr[14:13];
							addr_d  = instr[12:0];
							cnt_d   = 2'h0;
							ibyte_d = 1'b0;
							load_d  = 1'b1;
							state_d = ST_DATA;
						end
					end
				end
				ST_DATA: begin
					dsr_d = new_byte;
					if (pos_q == 3'h7) begin
						push   = ~rw_q;
						addr_d = step_addr(addr_q, lsb_first);
						cnt_d  = 2'(cnt_q + 2'h1);
						load_d = 1'b1;
						if (len_q == 2'h3) begin
							if (addr_q == `ADDR_LAST) begin
								state_d = ST_DONE;
							end
						end else if (cnt_q == len_q) begin
							state_d = ST_DONE;
						end
					end
				end
				default: begin
					pos_d = pos_q;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst_all) begin
			state_q <= ST_INSTR;
			pos_q   <= 3'h0;
			ibyte_q <= 1'b0;
			isr_q   <= 16'h0000;
			dsr_q   <= 8'h00;
			rw_q    <= 1'b0;
			len_q   <= 2'h0;
			cnt_q   <= 2'h0;
			addr_q  <= 13'h0000;
			load_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			pos_q   <= pos_d;
			ibyte_q <= ibyte_d;
			isr_q   <= isr_d;
			dsr_q   <= dsr_d;
			rw_q    <= rw_d;
			len_q   <= len_d;
			cnt_q   <= cnt_d;
			addr_q  <= addr_d;
			load_q  <= load_d;
		end
	end

	// stalled words wait here while the register side is held
	pair_buffer #(.WIDTH(21), .DEPTH(2)) u_wbuf (
		.clk_sys   (clk_sys),
		.reset     (rst_all),
		.in_valid  (push),
		.in_ready  (buf_ready),
		.in_data   ({addr_q, new_byte}),
		.out_valid (buf_valid),
		.out_ready (~reg_hold),
		.out_data  (buf_data)
	);

	// ==================================================================
	// readback path
	byte_t           tx_q, tx_d, rd_byte;
	logic [SLOT_W:0] rslot;
	logic            bit_q, bit_d, drive_q, drive_d;

	assign rslot = slot_of(addr_q);

	always_comb begin
		rd_byte = 8'h00;
		if (addr_q == `ADDR_PORT_CFG) begin
			rd_byte = port_cfg_q;
		end else if (addr_q == `ADDR_RB_SEL) begin
			rd_byte = rb_sel_q;
		end else if (rslot[SLOT_W]) begin
			rd_byte = rb_sel_q[`BIT_RB_ACTIVE] ? active_q[rslot[SLOT_W-1:0]]
				: shadow_q[rslot[SLOT_W-1:0]];
		end
		tx_d    = load_q ? rd_byte : tx_q;
		bit_d   = bit_q;
		drive_d = ~cs_s & (state_q == ST_DATA) & rw_q;
		if (fall) begin
			bit_d = lsb_first ? tx_q[pos_q] : tx_q[3'h7 - pos_q];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst_all) begin
			tx_q    <= 8'h00;
			bit_q   <= 1'b0;
			drive_q <= 1'b0;
		end else begin
			tx_q    <= tx_d;
			bit_q   <= bit_d;
			drive_q <= drive_d;
		end
	end

	// ==================================================================
	// outputs, all registered
	logic por_q;

	always_ff @(posedge clk_sys) begin
		if (rst_all) begin
			por_q                 <= 1'b1;
			write_ready           <= 1'b1;
			sdio_out              <= 1'b0;
			sdio_oe               <= 1'b0;
			separate_readback_pin <= 1'b0;
			separate_readback_oe  <= 1'b0;
			pll_pd                <= 1'b0;
			core_off              <= 1'b0;
			dist_pd               <= 1'b0;
			sync_hold             <= 1'b1;
			pecl_mode             <= '0;
			lvds_off              <= '0;
		end else begin
			por_q                 <= 1'b0;
			write_ready           <= buf_ready;
			sdio_out              <= bit_d;
			sdio_oe               <= drive_d & ~unidir;
			separate_readback_pin <= bit_d;
			separate_readback_oe  <= drive_d & unidir;
			pll_pd                <= pll_pd_d | sleep_s;
			core_off              <= sleep_s;
			dist_pd               <= active_d[SL_DIST][`BIT_DIST_PD];
			// release of the last of these to clear is the output sync point
			sync_hold             <= por_q | soft_rst | sleep_s
				| active_d[SL_DIST][`BIT_DIST_PD];
			for (int i = 0; i < N_PECL; i++) begin
				pecl_mode[2*i +: 2] <= sleep_s ? `PECL_SAFE_PD
					: active_d[i+1][1:0];
			end
			for (int i = 0; i < N_LVDS; i++) begin
				lvds_off[i] <= sleep_s | active_d[SL_LVDS+i][`BIT_LVDS_PD]
					| active_d[SL_DIST][`BIT_DIST_PD];
			end
		end
	end
endmodule

`default_nettype wire

// [common/clkctl_params.svh]
// offsets, field positions, reset values and counts of the clock chip control port
`ifndef CLKCTL_PARAMS_SVH
`define CLKCTL_PARAMS_SVH

// ======================================================================
// register addresses
`define ADDR_PORT_CFG   13'h000
`define ADDR_RB_SEL     13'h004
`define ADDR_PLL_MODE   13'h010
`define ADDR_PECL_BASE  13'h0F0
`define ADDR_LVDS_BASE  13'h140
`define ADDR_DIST       13'h230
`define ADDR_UPDATE     13'h232
`define ADDR_LAST       13'h232

// ======================================================================
// field positions
`define BIT_UNIDIR      0
`define BIT_LSB_FIRST   1
`define BIT_SRST        2
`define BIT_SRST_MIRROR 5
`define BIT_RB_ACTIVE   0
`define BIT_UPDATE      0
`define BIT_DIST_PD     1
`define BIT_LVDS_PD     0

// ======================================================================
// reset values and encodings
`define RST_PORT_CFG    8'h18
`define RST_RB_SEL      8'h00
`define RST_CFG_REG     8'h00
`define PLL_ASYNC_PD    2'h1
`define PLL_SYNC_PD     2'h3
`define PECL_NORMAL     2'h0
`define PECL_SAFE_PD    2'h2
`define PECL_TOTAL_PD   2'h3

// ======================================================================
// counts
`define INSTR_BYTES     2
`define N_PECL_OUT      6
`define N_LVDS_OUT      4

`endif

// [common/clkctl_pkg.sv]
// types shared by the clock chip control port
`default_nettype none

package clkctl_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [12:0] addr_t;
	typedef enum logic [1:0] {
		ST_INSTR,
		ST_DATA,
		ST_DONE
	} port_state_t;
endpackage

`default_nettype wire

// [rtl/pair_buffer.sv]
// two-entry buffer with valid and ready on both sides
`default_nettype none

module pair_buffer #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             reset,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
	logic [PW:0]      cnt_q, cnt_d;
	logic             push, pop;

	assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
		step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	always_comb begin
		mem_d = mem_q;
		wr_d  = wr_q;
		rd_d  = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wr_q] = in_data;
			wr_d        = step(wr_q);
		end
		if (pop) begin
			rd_d = step(rd_q);
		end
		if (push && !pop) begin
			cnt_d = (PW+1)'(cnt_q + 1'b1);
		end else if (pop && !push) begin
			cnt_d = (PW+1)'(cnt_q - 1'b1);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
		mem_q <= mem_d;
	end
endmodule

`default_nettype wire

// [sim/clkctl_port_sva.sv]
// assertion checker bound to the clock chip control port
`default_nettype none

module clkctl_port_sva #(
	parameter int N_PECL = 6,
	parameter int N_LVDS = 4
) (
	// clock and pins
	input wire logic                clk_sys,
	input wire logic                reset,
	input wire logic                reset_pin_n,
	input wire logic                sleep_pin_n,
	input wire logic                sclk,
	input wire logic                cs_n,
	input wire logic                reg_hold,
	// outputs watched
	input wire logic                sdio_out,
	input wire logic                sdio_oe,
	input wire logic                separate_readback_oe,
	input wire logic                write_ready,
	input wire logic                pll_pd,
	input wire logic                core_off,
	input wire logic                dist_pd,
	input wire logic                sync_hold,
	input wire logic [2*N_PECL-1:0] pecl_mode,
	input wire logic [N_LVDS-1:0]   lvds_off
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	// ======================================================================
	// serial pins
	a_cs_tristate: assert property (cs_n [*5] |-> !sdio_oe && !separate_readback_oe)
		else $error("output enable while deselected");
	a_oe_exclusive: assert property (!(sdio_oe && separate_readback_oe))
		else $error("both data outputs enabled");
	// read bits move only while sclk has been low for a while
	a_read_edge: assert property (sdio_oe && $past(sdio_oe) && $changed(sdio_out)
		|-> !$past(sclk, 2))
		else $error("read bit changed after a rising serial clock");
	a_drain_ready: assert property ((!reg_hold) [*3] |-> write_ready)
		else $error("buffer stays full while draining is allowed");

	// ======================================================================
	// reset and power-down
	a_power_sync: assert property ($fell(reset) && reset_pin_n && sleep_pin_n
		|-> sync_hold ##[1:4] !sync_hold)
		else $error("no output sync after reset release");
	a_pin_reset: assert property ((!reset_pin_n) [*5] |-> sync_hold && !dist_pd && !pll_pd
		&& pecl_mode == '0 && lvds_off == '0)
		else $error("reset pin does not restore defaults");
	a_sleep_off: assert property ((!sleep_pin_n && reset_pin_n) [*5] |-> core_off && &lvds_off)
		else $error("core or outputs on during sleep");
	a_sleep_pecl: assert property ((!sleep_pin_n && reset_pin_n) [*5]
		|-> pecl_mode == {N_PECL{2'h2}})
		else $error("lvpecl outputs not in safe mode during sleep");
	a_dist_sync: assert property (dist_pd && $past(dist_pd) |-> sync_hold)
		else $error("outputs released while distribution is down");
endmodule

bind clkctl_port clkctl_port_sva #(.N_PECL(N_PECL), .N_LVDS(N_LVDS)) clkctl_port_sva_i (
	.clk_sys(clk_sys), .reset(reset), .reset_pin_n(reset_pin_n), .sleep_pin_n(sleep_pin_n),
	.sclk(sclk), .cs_n(cs_n), .reg_hold(reg_hold), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
	.separate_readback_oe(separate_readback_oe), .write_ready(write_ready), .pll_pd(pll_pd),
	.core_off(core_off), .dist_pd(dist_pd), .sync_hold(sync_hold), .pecl_mode(pecl_mode),
	.lvds_off(lvds_off));

`default_nettype wire

// [sim/clkctl_host.sv]
// serial master model standing in for the host controller
`default_nettype none

module clkctl_host import clkctl_pkg::*; (
	// clock
	input  wire logic clk_sys,
	// pins read by the host
	input  wire logic sdio_pin,
	input  wire logic rb_pin,
	// pins driven by the host
	output logic      sclk,
	output logic      cs_n,
	output logic      sdio_drv
);
	timeunit 1ns;
	timeprecision 1ns;
	logic lsb_mode = 1'b0;
	logic uni_mode = 1'b0;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdio_drv = 1'b1;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge clk_sys);
		#5;
	endtask
	// ======================================================================
	// bit and frame level
	// data is set while sclk is low and read just before the rise
	task automatic bits(input byte_t d, input int n, output byte_t q);
		for (int i = 0; i < n; i++) begin
			sdio_drv = lsb_mode ? d[i] : d[7-i];
			tk(6);
			q[lsb_mode ? i : 7-i] = uni_mode ? rb_pin : sdio_pin;
			sclk = 1'b1;
			tk(4);
			sclk = 1'b0;
		end
	endtask
	// stall: byte index before which cs is lifted; cut: bits of byte 0 before an abort
	task automatic xfer(input logic rw, input logic [1:0] len, input logic [12:0] a,
		input int nb, input logic [31:0] wd, input int stall, input int cut,
		output logic [31:0] rd);
		logic [15:0] ins;
		byte_t q;
		ins = {rw, len, a};
		rd = 32'h0;
		cs_n = 1'b0;
		tk(3);
		for (int k = -2; k < nb; k++) begin
			if (k == stall) begin
				cs_n = 1'b1;
				sdio_drv = ~sdio_drv;
				tk(8);
				cs_n = 1'b0;
				tk(3);
			end
			if (k < 0)
				bits((k == -2) ^ lsb_mode ? ins[15:8] : ins[7:0], 8, q);
			else if (k == 0 && cut > 0) begin
				bits(wd[7:0], cut, q);
				break;
			end else begin
				bits(rw ? 8'h55 : wd[8*k +: 8], 8, q);
				rd[8*k +: 8] = q;
			end
		end
		cs_n = 1'b1;
		sdio_drv = ~sdio_drv;
		tk(4);
	endtask
endmodule

`default_nettype wire

// [sim/test_clkctl_port.sv]
// self-checking bench of the clock chip control port
`include "clkctl_params.svh"
`default_nettype none

module test_clkctl_port import clkctl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0, reset = 1'b1, reset_pin_n = 1'b1, sleep_pin_n = 1'b1;
	logic cp_event = 1'b0, reg_hold = 1'b0;
	logic sclk, cs_n, sdio_drv, sdio_pin, rb_pin, sdio_out, sdio_oe, sep_pin, sep_oe;
	logic write_ready, pll_pd, core_off, dist_pd, sync_hold;
	logic [11:0] pecl_mode;
	logic [3:0]  lvds_off;
	int n_fail = 0, tests_run = 0, seed = 32'hC9183495;
	always #25 clk_sys = ~clk_sys;
	assign sdio_pin = sdio_oe ? sdio_out : sdio_drv;
	assign rb_pin = sep_oe ? sep_pin : ~sdio_drv;

	clkctl_port clkctl_port_i (.clk_sys(clk_sys), .reset(reset), .reset_pin_n(reset_pin_n),
		.sleep_pin_n(sleep_pin_n), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_pin),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe), .separate_readback_pin(sep_pin),
		.separate_readback_oe(sep_oe), .cp_event(cp_event), .reg_hold(reg_hold),
		.write_ready(write_ready), .pll_pd(pll_pd), .core_off(core_off), .dist_pd(dist_pd),
		.sync_hold(sync_hold), .pecl_mode(pecl_mode), .lvds_off(lvds_off));
	clkctl_host clkctl_host_i (.clk_sys(clk_sys), .sdio_pin(sdio_pin), .rb_pin(rb_pin),
		.sclk(sclk), .cs_n(cs_n), .sdio_drv(sdio_drv));

	// ======================================================================
	// helpers
	function automatic logic [3:0] exp_lvds(input logic [3:0] b, input logic all_off);
		return all_off ? 4'hF : b;
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge clk_sys);
		#5;
	endtask
	task automatic rd(input logic [1:0] len, input logic [12:0] a, input int nb,
		output logic [31:0] r);
		clkctl_host_i.xfer(1'b1, len, a, nb, 32'h0, 9, 0, r);
	endtask
	task automatic wr(input logic [12:0] a, input logic [1:0] len, input int nb,
		input logic [31:0] d, input int stall, input int cut);
		logic [31:0] r;
		clkctl_host_i.xfer(1'b0, len, a, nb, d, stall, cut, r);
		tk(4);
	endtask
	task automatic upd();
		wr(`ADDR_UPDATE, 2'h0, 1, 32'h1, 9, 0);
	endtask

	// ======================================================================
	// scenarios
	initial begin
		logic [31:0] d, r;
		tk(5);
		reset = 1'b0;
		tk(3);
		wr(`ADDR_PLL_MODE, 2'h0, 1, `PLL_SYNC_PD, 9, 0);
		upd();
		check(pll_pd, 32'h0);
		cp_event = 1'b1;
		tk(1);
		cp_event = 1'b0;
		tk(2);
		check(pll_pd, 32'h1);
		wr(`ADDR_PLL_MODE, 2'h0, 1, 32'h0, 9, 0);
		upd();
		wr(`ADDR_PLL_MODE, 2'h0, 1, `PLL_ASYNC_PD, 9, 0);
		upd();
		check(pll_pd, 32'h1);
		d = $random(seed);
		wr(`ADDR_PECL_BASE + 13'h2, 2'h2, 3, d, 9, 0);
		rd(2'h3, `ADDR_PECL_BASE + 13'h2, 4, r);
		check(r, {8'h00, d[23:0]});
		upd();
		check(pecl_mode, {26'h0, d[1:0], d[9:8], d[17:16]});
		d = $random(seed);
		wr(`ADDR_LVDS_BASE + 13'h3, 2'h3, 4, {7'h0, d[0], 7'h0, d[1], 7'h0, d[2], 7'h0, d[3]}, 9, 0);
		check(lvds_off, 32'h0);
		upd();
		check(lvds_off, exp_lvds(d[3:0], 1'b0));
		// soft reset acts at once, before it is cleared
		wr(`ADDR_PORT_CFG, 2'h0, 1, 32'h3C, 9, 0);
		check({pll_pd, lvds_off}, 32'h0);
		wr(`ADDR_PORT_CFG, 2'h0, 1, 32'h18, 9, 0);
		rd(2'h0, `ADDR_PECL_BASE + 13'h2, 1, r);
		check(r, 32'h0);
		wr(`ADDR_DIST, 2'h0, 1, 32'h2, 9, 0);
		upd();
		check({dist_pd, lvds_off}, {27'h0, 1'b1, exp_lvds(4'h0, 1'b1)});
		wr(`ADDR_DIST, 2'h0, 1, 32'h0, 9, 0);
		upd();
		tk(3);
		check({dist_pd, sync_hold}, 32'h0);
		sleep_pin_n = 1'b0;
		tk(6);
		check({core_off, lvds_off}, {27'h0, 1'b1, exp_lvds(4'h0, 1'b1)});
		wr(`ADDR_LVDS_BASE + 13'h1, 2'h0, 1, 32'h1, 9, 0);
		upd();
		rd(2'h0, `ADDR_LVDS_BASE + 13'h1, 1, r);
		check(r, 32'h1);
		sleep_pin_n = 1'b1;
		tk(6);
		check({core_off, lvds_off}, exp_lvds(4'h2, 1'b0));
		// stall inside the instruction, then an abort inside a data byte
		wr(`ADDR_LVDS_BASE + 13'h2, 2'h0, 1, 32'h1, -1, 0);
		wr(`ADDR_LVDS_BASE + 13'h2, 2'h0, 1, 32'h0, 0, 3);
		rd(2'h0, `ADDR_LVDS_BASE + 13'h2, 1, r);
		check(r, 32'h1);
		// two bytes fill the buffer while draining is held off
		reg_hold = 1'b1;
		d = $random(seed);
		wr(`ADDR_PECL_BASE + 13'h1, 2'h1, 2, d, 9, 0);
		check(write_ready, 32'h0);
		reg_hold = 1'b0;
		tk(4);
		rd(2'h1, `ADDR_PECL_BASE + 13'h1, 2, r);
		check(r, {16'h0, d[15:0]});
		// active copy still holds the cleared value, shadow holds the new byte
		wr(`ADDR_RB_SEL, 2'h0, 1, 32'h1, 9, 0);
		rd(2'h0, `ADDR_PECL_BASE + 13'h1, 1, r);
		check(r, 32'h0);
		wr(`ADDR_RB_SEL, 2'h0, 1, 32'h0, 9, 0);
		wr(`ADDR_PORT_CFG, 2'h0, 1, 32'hDB, 9, 0);
		clkctl_host_i.lsb_mode = 1'b1;
		clkctl_host_i.uni_mode = 1'b1;
		d = $random(seed);
		wr(`ADDR_PECL_BASE, 2'h1, 2, d, 9, 0);
		rd(2'h1, `ADDR_PECL_BASE, 2, r);
		check(r, {16'h0, d[15:0]});
		wr(`ADDR_PORT_CFG, 2'h0, 1, 32'h18, 9, 0);
		clkctl_host_i.lsb_mode = 1'b0;
		clkctl_host_i.uni_mode = 1'b0;
		rd(2'h3, 13'h001, 4, r);
		check(r, 32'h55001800);
		wr(`ADDR_LVDS_BASE, 2'h0, 1, 32'h1, 9, 0);
		upd();
		reset_pin_n = 1'b0;
		tk(6);
		reset_pin_n = 1'b1;
		tk(4);
		check(lvds_off, 32'h0);
		rd(2'h0, `ADDR_LVDS_BASE + 13'h1, 1, r);
		check(r, 32'h0);
		print_verdict();
	end

	// cuts a hang short well past the expected run length
	initial begin
		repeat (60000) @(posedge clk_sys);
		n_fail++;
		print_verdict();
	end
endmodule

`default_nettype wire
